// >>> verilog/pmlc_cfg.sv
// bus tenure timer, access interval and memory window base configuration registers
`include "pmlc_regs.svh"

module pmlc_cfg
	import pmlc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire pmlc_cfg_req_s cfg_req,
	input  wire pmlc_ee_s      ee_param,
	input  wire logic          frame_start,
	input  wire logic          tenure_done,
	input  wire logic          gnt_n,
	output logic [31:0]        cfg_rdata_q,
	output logic               cfg_rvalid_q,
	output logic               tenure_expired_q,
	output logic               bus_release_q,
	output logic [24:0]        mem_base_q,
	output logic               mem_decode_en_q,
	output logic               mem_below_1m_q
);

	// grant comes from the arbiter pin, so it is synchronised before use
	logic       gnt_n_meta_q;
	logic       gnt_n_sync_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gnt_n_meta_q <= 1'b1;
			gnt_n_sync_q <= 1'b1;
		end else begin
			gnt_n_meta_q <= gnt_n;
			gnt_n_sync_q <= gnt_n_meta_q;
		end
	end

	// dword hit test; byte offsets are kept as printed and lanes chosen from the low bits
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	function automatic logic lane(input logic [3:0] be, input logic [7:0] ofs);
		lane = be[ofs[1:0]];
	endfunction : lane

	// register state
	logic [7:0]  tenure_q, tenure_d;
	logic [7:0]  interval_q, interval_d;
	logic [24:0] mem_base_d;
	logic        mem_decode_en_d;
	logic        mem_below_1m_d;
	logic [31:0] membase_rd;

	// whole window reads zero while disabled so software sizes nothing
	assign membase_rd = mem_decode_en_q ?
		{mem_base_q, 4'h0, 1'b0, mem_below_1m_q, 1'b1} : 32'h0;

	always_comb begin
		tenure_d        = tenure_q;
		interval_d      = interval_q;
		mem_base_d      = mem_base_q;
		mem_decode_en_d = mem_decode_en_q;
		mem_below_1m_d  = mem_below_1m_q;
		if (cfg_req.wr) begin
			if (hit(cfg_req.addr, `PMLC_OFS_TENURE) && lane(cfg_req.be, `PMLC_OFS_TENURE)) begin
				// only the upper five bits store; low three stay zero
				tenure_d = cfg_req.wdata[15:8] & `PMLC_TENURE_WMASK;
			end else if (hit(cfg_req.addr, `PMLC_OFS_MEMBASE) && mem_decode_en_q) begin
				if (cfg_req.be[0]) begin
					mem_base_d[0] = cfg_req.wdata[7];
				end
				if (cfg_req.be[1]) begin
					mem_base_d[8:1] = cfg_req.wdata[15:8];
				end
				if (cfg_req.be[2]) begin
					mem_base_d[16:9] = cfg_req.wdata[23:16];
				end
				if (cfg_req.be[3]) begin
					mem_base_d[24:17] = cfg_req.wdata[31:24];
				end
			end
		end
		// eeprom load that disables the window wins over a base write in the same cycle; a base write lands only if the window was already enabled
		if (ee_param.load) begin
			interval_d[`PMLC_EE_INTERVAL_MSB:`PMLC_EE_INTERVAL_LSB] =
				ee_param.word[`PMLC_EE_INTERVAL_MSB:`PMLC_EE_INTERVAL_LSB];
			mem_decode_en_d = ~ee_param.word[`PMLC_EE_MEMBAR_DIS];
			mem_below_1m_d  = ee_param.word[`PMLC_EE_LOWER1M];
			if (ee_param.word[`PMLC_EE_MEMBAR_DIS]) begin
				mem_base_d = 25'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tenure_q        <= `PMLC_TENURE_RST;
			interval_q      <= `PMLC_INTERVAL_RST;
			mem_base_q      <= 25'h0;
			mem_decode_en_q <= 1'b0;
			mem_below_1m_q  <= 1'b0;
		end else begin
			tenure_q        <= tenure_d;
			interval_q      <= interval_d;
			mem_base_q      <= mem_base_d;
			mem_decode_en_q <= mem_decode_en_d;
			mem_below_1m_q  <= mem_below_1m_d;
		end
	end

	// read path: one cycle from strobe to data, unmapped bytes read zero
	logic [31:0] rdata_d;
	logic        rvalid_d;

	always_comb begin
		rdata_d  = 32'h0;
		rvalid_d = cfg_req.rd;
		if (cfg_req.rd) begin
			if (hit(cfg_req.addr, `PMLC_OFS_TENURE)) begin
				rdata_d = {16'h0, tenure_q, 8'h0};
			end else if (hit(cfg_req.addr, `PMLC_OFS_MEMBASE)) begin
				rdata_d = membase_rd;
			end else if (hit(cfg_req.addr, `PMLC_OFS_INTERVAL)) begin
				rdata_d = {interval_q, 24'h0};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_rdata_q  <= 32'h0;
			cfg_rvalid_q <= 1'b0;
		end else begin
			cfg_rdata_q  <= rdata_d;
			cfg_rvalid_q <= rvalid_d;
		end
	end

	// tenure timer: register value is already eight-clock units times eight, so it counts clocks
	pmlc_tenure_e state_q, state_d;
	logic [7:0]   cnt_q, cnt_d;
	logic         expired_d;
	logic         release_d;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (frame_start) begin
			state_d = PMLC_RUN;
			cnt_d   = tenure_q;
		end else begin
			case (state_q)
				PMLC_RUN: begin
					if (tenure_done) begin
						state_d = PMLC_IDLE;
					end else if (cnt_q <= 8'h01) begin
						state_d = PMLC_EXPIRED;
						cnt_d   = 8'h00;
					end else begin
						cnt_d = cnt_q - 8'h01;
					end
				end
				PMLC_EXPIRED: begin
					if (tenure_done) begin
						state_d = PMLC_IDLE;
					end
				end
				default: begin
					state_d = PMLC_IDLE;
				end
			endcase
		end
		expired_d = (state_d == PMLC_EXPIRED);
		// release only once the arbiter has taken grant away
		release_d = (state_q == PMLC_EXPIRED) && gnt_n_sync_q && !tenure_done && !frame_start;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q          <= PMLC_IDLE;
			cnt_q            <= 8'h00;
			tenure_expired_q <= 1'b0;
			bus_release_q    <= 1'b0;
		end else begin
			state_q          <= state_d;
			cnt_q            <= cnt_d;
			tenure_expired_q <= expired_d;
			bus_release_q    <= release_d;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// run length and the tenure value captured at the start, so a mid-run write cannot skew the check
	logic [8:0] run_len_q;
	logic [7:0] run_target_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_len_q    <= 9'h0;
			run_target_q <= 8'h00;
		end else if (frame_start) begin
			run_len_q    <= 9'h0;
			run_target_q <= tenure_q;
		end else if (state_q == PMLC_RUN) begin
			run_len_q <= run_len_q + 9'h001;
		end
	end

	property p_tenure_low_zero;
		tenure_q[2:0] == 3'h0;
	endproperty
	a_tenure_low_zero: assert property (p_tenure_low_zero) else $error("tenure low bits set");

	property p_start_runs;
		frame_start |=> (state_q == PMLC_RUN) && (cnt_q == $past(tenure_q));
	endproperty
	a_start_runs: assert property (p_start_runs) else $error("timer not started");

	property p_expire_time;
		$rose(state_q == PMLC_EXPIRED) && !$past(frame_start) |->
			run_len_q == ((run_target_q == 8'h00) ? 9'h001 : {1'b0, run_target_q});
	endproperty
	a_expire_time: assert property (p_expire_time) else $error("expiry out of time");

	property p_no_early_expiry;
		(state_q == PMLC_RUN) && (cnt_q > 8'h01) && !frame_start |=> state_q != PMLC_EXPIRED;
	endproperty
	a_no_early_expiry: assert property (p_no_early_expiry) else $error("expired early");

	property p_release_cause;
		bus_release_q |-> $past(state_q == PMLC_EXPIRED) && $past(gnt_n_sync_q);
	endproperty
	a_release_cause: assert property (p_release_cause) else $error("release without cause");

	property p_release_follows;
		(state_q == PMLC_EXPIRED) && gnt_n_sync_q && !tenure_done && !frame_start |=> bus_release_q;
	endproperty
	a_release_follows: assert property (p_release_follows) else $error("release missing");

	property p_interval_load;
		ee_param.load |=> interval_q[5:1] == $past(ee_param.word[5:1]) &&
			interval_q[7:6] == $past(interval_q[7:6]) && interval_q[0] == $past(interval_q[0]);
	endproperty
	a_interval_load: assert property (p_interval_load) else $error("interval load wrong");

	property p_membase_read;
		cfg_req.rd && hit(cfg_req.addr, `PMLC_OFS_MEMBASE) |=>
			cfg_rvalid_q && cfg_rdata_q[6:2] == 5'h0 && cfg_rdata_q[2] == 1'b0 &&
			cfg_rdata_q[0] == $past(mem_decode_en_q);
	endproperty
	a_membase_read: assert property (p_membase_read) else $error("membase read wrong");

	property p_disabled_holds;
		!mem_decode_en_q && !ee_param.load |=> mem_base_q == $past(mem_base_q);
	endproperty
	a_disabled_holds: assert property (p_disabled_holds) else $error("disabled base written");

	property p_maptype_load;
		ee_param.load |=> mem_below_1m_q == $past(ee_param.word[`PMLC_EE_LOWER1M]);
	endproperty
	a_maptype_load: assert property (p_maptype_load) else $error("map type not loaded");

	c_expire: cover property ((state_q == PMLC_RUN) ##[1:300] bus_release_q);
	c_membase_wr: cover property (cfg_req.wr && hit(cfg_req.addr, `PMLC_OFS_MEMBASE) && mem_decode_en_q);
	c_ee_load: cover property (ee_param.load ##1 cfg_req.rd);

endmodule : pmlc_cfg

// >>> verilog/pmlc_regs.svh
// offsets, field positions, reset values and timing counts of the configuration registers
// Function
// - tenure field counts in units of eight bus clocks, bounding bus ownership.
// - tenure timer starts each time a bus-master frame is begun.
// - after timer expiry, give up bus once grant is deasserted.
// - tenure register at 0x0d, resets 0x00, low three bits reserved, upper five writable.
// - read-only access interval in 250 ns units, default 0x0a.
// - access interval bits 5..1 load from eeprom parameter word.
// - memory base register may be disabled by eeprom parameter word.
// - bit 0 of memory base is read-only, one when base is valid.
// - mapping type bit 2 is zero, bit 1 from below-one-megabyte flag.
// - type 00 anywhere in 32 bits, 01 lowest megabyte, 1x undefined.
// - memory base bits 31..7 writable, decoding a 128-byte block.
`ifndef PMLC_REGS_SVH
`define PMLC_REGS_SVH

`define PMLC_OFS_TENURE      8'h0d
`define PMLC_OFS_MEMBASE     8'h14
`define PMLC_OFS_INTERVAL    8'h3f

`define PMLC_TENURE_RST      8'h00
`define PMLC_TENURE_WMASK    8'hf8
`define PMLC_TENURE_UNIT     8
`define PMLC_INTERVAL_RST    8'h0a
`define PMLC_INTERVAL_UNIT_NS 250
`define PMLC_CLK_NS          25
`define PMLC_INTERVAL_UNIT_CYC (`PMLC_INTERVAL_UNIT_NS / `PMLC_CLK_NS)
`define PMLC_MEMBASE_RST     32'h00000000
`define PMLC_MEMBASE_LSB     7
`define PMLC_MAPTYPE_ANY     2'h0
`define PMLC_MAPTYPE_LOW1M   2'h1

`define PMLC_EE_INTERVAL_MSB 5
`define PMLC_EE_INTERVAL_LSB 1
`define PMLC_EE_MEMBAR_DIS   6
`define PMLC_EE_LOWER1M      7

`endif

// >>> verilog/pmlc_pkg.sv
// types shared by the configuration register block
package pmlc_pkg;
	typedef struct packed {
		logic [7:0]  addr;
		logic        wr;
		logic        rd;
		logic [3:0]  be;
		logic [31:0] wdata;
	} pmlc_cfg_req_s;

	typedef struct packed {
		logic        load;
		logic [15:0] word;
	} pmlc_ee_s;

	typedef enum logic [1:0] {
		PMLC_IDLE,
		PMLC_RUN,
		PMLC_EXPIRED
	} pmlc_tenure_e;
endpackage : pmlc_pkg

// >>> dv/pmlc_arb_model.sv
// behavioural arbiter standing on the far side of the tenure logic
module pmlc_arb_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic other_req,
	output logic      gnt_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// grant is withdrawn one edge after another master asks; no grant while in reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gnt_n <= 1'b1;
		end else begin
			gnt_n <= other_req;
		end
	end
endmodule : pmlc_arb_model

// >>> dv/test_pmlc_cfg.sv
// self-checking bench for the configuration register block
module test_pmlc_cfg;
	import pmlc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic          clk, rst, frame_start, tenure_done, gnt_n, other_req;
	pmlc_cfg_req_s cfg_req;
	pmlc_ee_s      ee_param;
	logic [31:0]   cfg_rdata_q;
	logic [24:0]   mem_base_q;
	logic          cfg_rvalid_q, tenure_expired_q, bus_release_q;
	logic          mem_decode_en_q, mem_below_1m_q;
	int            failures, comparisons, n;

	pmlc_cfg uut (.clk(clk), .rst(rst), .cfg_req(cfg_req), .ee_param(ee_param),
		.frame_start(frame_start), .tenure_done(tenure_done), .gnt_n(gnt_n),
		.cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
		.tenure_expired_q(tenure_expired_q), .bus_release_q(bus_release_q),
		.mem_base_q(mem_base_q), .mem_decode_en_q(mem_decode_en_q),
		.mem_below_1m_q(mem_below_1m_q));
	pmlc_arb_model arb (.clk(clk), .rst(rst), .other_req(other_req), .gnt_n(gnt_n));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one bus cycle, strobe held for exactly one taking edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [3:0] be,
			input logic [31:0] d);
		@(negedge clk);
		cfg_req = '{a, w, !w, be, d};
		@(negedge clk);
		cfg_req = '0;
	endtask : bus

	// the answer stands only in the cycle after the taking edge, so it is judged there
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 4'h0, 32'h0);
		chk({31'h0, cfg_rvalid_q}, 32'h1);
		chk(cfg_rdata_q, exp);
	endtask : rd

	task automatic ee(input logic [15:0] w);
		@(negedge clk);
		ee_param = '{1'b1, w};
		@(negedge clk);
		ee_param = '0;
	endtask : ee

	task automatic timed_out(input int k, input int lim);
		if (k >= lim) begin
			failures++;
			$display("Error at %0t: wait ran out", $time);
			give_verdict();
		end
	endtask : timed_out

	task automatic test_reset_values();
		rd(8'h0c, 32'h0);
		rd(8'h3c, 32'h0a000000);
		rd(8'h14, 32'h0);
		rd(8'h20, 32'h0);
		$display("reset values done");
	endtask : test_reset_values

	task automatic test_tenure_field();
		bus(8'h0c, 1'b1, 4'hf, 32'hffffffff);
		rd(8'h0c, 32'h0000f800);
		bus(8'h0c, 1'b1, 4'hd, 32'h00000000);
		rd(8'h0c, 32'h0000f800);
		$display("tenure field done");
	endtask : test_tenure_field

	task automatic test_window();
		ee(16'h00bc);
		chk({30'h0, mem_decode_en_q, mem_below_1m_q}, 32'h3);
		rd(8'h3c, 32'h3c000000);
		bus(8'h3c, 1'b1, 4'h8, 32'h55000000);
		rd(8'h3c, 32'h3c000000);
		rd(8'h14, 32'h00000003);
		bus(8'h14, 1'b1, 4'hf, 32'hffffffff);
		rd(8'h14, 32'hffffff83);
		chk({7'h0, mem_base_q}, 32'h01ffffff);
		ee(16'h0002);
		// enabling again keeps the base that software wrote
		rd(8'h14, 32'hffffff81);
		rd(8'h3c, 32'h02000000);
		ee(16'h0040);
		chk({7'h0, mem_base_q}, 32'h0);
		chk({30'h0, mem_decode_en_q, mem_below_1m_q}, 32'h0);
		rd(8'h14, 32'h0);
		bus(8'h14, 1'b1, 4'hf, 32'h12345680);
		rd(8'h14, 32'h0);
		rd(8'h3c, 32'h00000000);
		$display("memory window done");
	endtask : test_window

	// tenure of 8 clocks, grant kept until the arbiter sees another master
	task automatic test_timer();
		bus(8'h0c, 1'b1, 4'h2, 32'h00000800);
		@(negedge clk);
		frame_start = 1'b1;
		@(negedge clk);
		frame_start = 1'b0;
		for (n = 1; n < 20 && tenure_expired_q !== 1'b1; n++) @(negedge clk);
		timed_out(n, 20);
		// start edge plus eight clocks: expiry first seen at the ninth falling edge
		chk(n, 32'h9);
		repeat (4) @(negedge clk);
		chk({31'h0, bus_release_q}, 32'h0);
		other_req = 1'b1;
		for (n = 0; n < 6 && bus_release_q !== 1'b1; n++) @(negedge clk);
		timed_out(n, 6);
		@(negedge clk);
		frame_start = 1'b1;
		@(negedge clk);
		frame_start = 1'b0;
		chk({30'h0, tenure_expired_q, bus_release_q}, 32'h0);
		tenure_done = 1'b1;
		@(negedge clk);
		tenure_done = 1'b0;
		other_req = 1'b0;
		repeat (2) @(negedge clk);
		chk({30'h0, tenure_expired_q, bus_release_q}, 32'h0);
		$display("tenure timer done");
	endtask : test_timer

	initial begin
		rst = 1'b1;
		cfg_req = '0;
		ee_param = '0;
		frame_start = 1'b0;
		tenure_done = 1'b0;
		other_req = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		test_reset_values();
		test_tenure_field();
		test_window();
		test_timer();
		give_verdict();
	end
endmodule : test_pmlc_cfg
